// ---- src/bridge_ctl_pkg.sv ----
package bridge_ctl_pkg;

  localparam logic [7:0]  OFF_BRIDGE_CONTROL = 8'h3C;
  localparam logic [7:0]  OFF_PM_CAPABILITY  = 8'h40;

  // Bridge control field positions in the 32-bit word
  localparam int unsigned POS_POISON_EN   = 16;
  localparam int unsigned POS_ERR_FWD_EN  = 17;
  localparam int unsigned POS_ISA_EN      = 18;
  localparam int unsigned POS_DISPLAY_EN  = 19;
  localparam int unsigned POS_DISP_16BIT  = 20;
  localparam int unsigned POS_SEC_RESET   = 22;

  // Writable mask of the bridge control word
  localparam logic [31:0] BRIDGE_CTL_WMASK = 32'h005F_0000;
  localparam logic [31:0] BRIDGE_CTL_RESET = 32'h0000_0000;

  // Capability header fields
  localparam logic [7:0]  PM_CAP_ID       = 8'h01;
  localparam logic [7:0]  PM_NEXT_PTR     = 8'h48;
  localparam logic [2:0]  PM_REVISION     = 3'h3;
  localparam logic [4:0]  PM_WAKE_SUPPORT = 5'h19;

  // Legacy display and ISA decode windows
  localparam logic [31:0] DISP_MEM_LO   = 32'h000A_0000;
  localparam logic [31:0] DISP_MEM_HI   = 32'h000B_FFFF;
  localparam logic [9:0]  DISP_IO_A_LO  = 10'h3B0;
  localparam logic [9:0]  DISP_IO_A_HI  = 10'h3BB;
  localparam logic [9:0]  DISP_IO_B_LO  = 10'h3C0;
  localparam logic [9:0]  DISP_IO_B_HI  = 10'h3DF;
  localparam logic [9:0]  ISA_TOP_LO    = 10'h100;
  localparam logic [31:0] IO_FIRST_64K  = 32'h0000_FFFF;

  localparam int unsigned NUM_DOWN_PORTS = 8;

endpackage

// ---- src/bridge_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
module bridge_decode
  import bridge_ctl_pkg::*;
(
  // Control
  input  wire logic        i_isa_en,
  input  wire logic        i_disp_en,
  input  wire logic        i_disp_16bit,
  // Request
  input  wire logic [31:0] i_addr,
  input  wire logic        i_is_io,
  input  wire logic        i_in_io_window,
  // Result
  output logic             o_isa_upstream,
  output logic             o_disp_forward
);

  logic low64k;
  logic disp_io_low;
  logic disp_io_hit;
  logic disp_mem_hit;

  assign low64k = (i_addr <= IO_FIRST_64K);

  // Top 768 bytes of each 1KB block in the first 64KB, inside the I/O window
  assign o_isa_upstream = i_isa_en & i_is_io & i_in_io_window & low64k
                        & (i_addr[9:0] >= ISA_TOP_LO);

  assign disp_io_low = ((i_addr[9:0] >= DISP_IO_A_LO) &&
                        (i_addr[9:0] <= DISP_IO_A_HI)) ||
                       ((i_addr[9:0] >= DISP_IO_B_LO) &&
                        (i_addr[9:0] <= DISP_IO_B_HI));

  // 10-bit mode aliases across all of I/O space
  assign disp_io_hit = disp_io_low &
                       (i_disp_16bit ? (i_addr[15:10] == 6'h00) & low64k
                                     : 1'b1);

  assign disp_mem_hit = (i_addr >= DISP_MEM_LO) && (i_addr <= DISP_MEM_HI);

  assign o_disp_forward = i_disp_en &
                          (i_is_io ? disp_io_hit : disp_mem_hit);

endmodule
`default_nettype wire

// ---- src/bridge_control_pm_capability.sv ----
`timescale 1ns/10ps
`default_nettype none
module bridge_control_pm_capability
  import bridge_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  // Port role
  input  wire logic                      i_is_upstream,
  // Configuration access
  input  wire logic                      i_cfg_wr,
  input  wire logic                      i_cfg_rd,
  input  wire logic [7:0]                i_cfg_addr,
  input  wire logic [3:0]                i_cfg_be,
  input  wire logic [31:0]               i_cfg_wdata,
  output logic      [31:0]               o_cfg_rdata,
  output logic                           o_cfg_rvalid,
  // Forwarding decisions
  input  wire logic [31:0]               i_req_addr,
  input  wire logic                      i_req_is_io,
  input  wire logic                      i_req_in_io_window,
  output logic                           o_isa_upstream,
  output logic                           o_disp_forward,
  // Error traffic
  input  wire logic                      i_sec_poisoned,
  input  wire logic                      i_sec_err_msg,
  output logic                           o_poison_report,
  output logic                           o_err_msg_forward,
  // Resets
  input  wire logic [NUM_DOWN_PORTS-1:0] i_up_sec_reset,
  output logic                           o_hot_reset,
  output logic                           o_port_rst_n
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] bridge_ctl_reg;
  logic [31:0] bridge_ctl_next;
  logic [31:0] be_mask;
  logic [31:0] pm_cap_word;
  logic        sec_reset;

  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  assign be_mask = lanes(i_cfg_be) & BRIDGE_CTL_WMASK;

  // Only writable bits change; reserved bits stay zero
  always_comb begin
    bridge_ctl_next = bridge_ctl_reg;
    if (i_cfg_wr && (i_cfg_addr == OFF_BRIDGE_CONTROL)) begin
      bridge_ctl_next = (bridge_ctl_reg & ~be_mask)
                      | (i_cfg_wdata & be_mask);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bridge_ctl_reg <= BRIDGE_CTL_RESET;
    end else begin
      bridge_ctl_reg <= bridge_ctl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hardwired header; writes have no path here
  assign pm_cap_word = {PM_WAKE_SUPPORT,
                        1'b0, 1'b0,
                        3'h0,
                        1'b0,
                        1'b0,
                        1'b0,
                        PM_REVISION,
                        PM_NEXT_PTR,
                        PM_CAP_ID};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cfg_rdata  <= 32'h0000_0000;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg_rd;
      case (i_cfg_addr)
        OFF_BRIDGE_CONTROL: o_cfg_rdata <= bridge_ctl_reg;
        OFF_PM_CAPABILITY:  o_cfg_rdata <= pm_cap_word;
        default:            o_cfg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered so the reset pin never glitches on decode
  assign sec_reset = bridge_ctl_reg[POS_SEC_RESET] |
                     (~i_is_upstream & (|i_up_sec_reset));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_hot_reset       <= 1'b0;
      o_port_rst_n      <= 1'b1;
      o_poison_report   <= 1'b0;
      o_err_msg_forward <= 1'b0;
    end else begin
      o_hot_reset       <= bridge_ctl_reg[POS_SEC_RESET];
      o_port_rst_n      <= ~(~i_is_upstream & sec_reset);
      o_poison_report   <= i_sec_poisoned &
                           bridge_ctl_reg[POS_POISON_EN];
      o_err_msg_forward <= i_sec_err_msg &
                           bridge_ctl_reg[POS_ERR_FWD_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic isa_up_c;
  logic disp_fwd_c;

  bridge_decode u_decode (
    .i_isa_en       (bridge_ctl_reg[POS_ISA_EN]),
    .i_disp_en      (bridge_ctl_reg[POS_DISPLAY_EN]),
    .i_disp_16bit   (bridge_ctl_reg[POS_DISP_16BIT]),
    .i_addr         (i_req_addr),
    .i_is_io        (i_req_is_io),
    .i_in_io_window (i_req_in_io_window),
    .o_isa_upstream (isa_up_c),
    .o_disp_forward (disp_fwd_c)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_isa_upstream <= 1'b0;
      o_disp_forward <= 1'b0;
    end else begin
      o_isa_upstream <= isa_up_c;
      o_disp_forward <= disp_fwd_c;
    end
  end

endmodule
`default_nettype wire

// ---- verif/bridge_control_pm_capability_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module bridge_control_pm_capability_sva (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_is_upstream,
  input wire logic        i_cfg_wr,
  input wire logic        i_cfg_rd,
  input wire logic [7:0]  i_cfg_addr,
  input wire logic [3:0]  i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic        o_cfg_rvalid,
  input wire logic [31:0] i_req_addr,
  input wire logic        i_req_is_io,
  input wire logic        o_disp_forward,
  input wire logic        i_sec_poisoned,
  input wire logic        i_sec_err_msg,
  input wire logic        o_poison_report,
  input wire logic        o_err_msg_forward,
  input wire logic        o_hot_reset,
  input wire logic        o_port_rst_n
);
  // Shadow of the writable control bits
  logic [31:0] sh_reg;
  logic        vld_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst)
      sh_reg <= 32'h0;
    else if (i_cfg_wr && i_cfg_addr == 8'h3C && i_cfg_be[2])
      sh_reg <= i_cfg_wdata & 32'h005F_0000;
  end
  // Masks $past across a mid-run reset
  always_ff @(posedge i_clk) vld_reg <= !i_rst;
  ////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_pm_rd;
    i_cfg_rd && i_cfg_addr == 8'h40;
  endsequence
  sequence s_ctl_rd;
    i_cfg_rd && i_cfg_addr == 8'h3C;
  endsequence
  property p_pm_read;
    s_pm_rd |=> o_cfg_rvalid && o_cfg_rdata == 32'hC803_4801;
  endproperty
  property p_ctl_read;
    s_ctl_rd |=> o_cfg_rvalid && o_cfg_rdata == $past(sh_reg);
  endproperty
  property p_poison;
    vld_reg |-> o_poison_report == $past(i_sec_poisoned && sh_reg[16]);
  endproperty
  property p_err;
    vld_reg |-> o_err_msg_forward == $past(i_sec_err_msg && sh_reg[17]);
  endproperty
  property p_mem;
    vld_reg && $past(!i_req_is_io && i_req_addr >= 32'h000A_0000 &&
      i_req_addr <= 32'h000B_FFFF) |-> o_disp_forward == $past(sh_reg[19]);
  endproperty
  property p_hot;
    vld_reg |-> o_hot_reset == $past(sh_reg[22]);
  endproperty
  property p_dn_rst;
    vld_reg && !i_is_upstream && $past(sh_reg[22]) |-> !o_port_rst_n;
  endproperty
  property p_up_rst;
    i_is_upstream && $past(i_is_upstream) |-> o_port_rst_n;
  endproperty
  a_pm_read: assert property (p_pm_read)
    else $error("capability header read wrong");
  a_ctl_read: assert property (p_ctl_read)
    else $error("control word read wrong");
  a_poison: assert property (p_poison)
    else $error("poison report wrong");
  a_err: assert property (p_err)
    else $error("error forward wrong");
  a_mem: assert property (p_mem)
    else $error("display memory forward wrong");
  a_hot: assert property (p_hot)
    else $error("hot reset wrong");
  a_dn_rst: assert property (p_dn_rst)
    else $error("port reset not asserted");
  a_up_rst: assert property (p_up_rst)
    else $error("upstream port reset asserted");
endmodule
`default_nettype wire

// ---- verif/down_device_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module down_device_model (
  input  wire logic i_clk,
  input  wire logic i_port_rst_n,
  input  wire logic i_send,
  output logic      o_err_msg
);
  // Held in reset, the device stays silent
  always_ff @(posedge i_clk) o_err_msg <= i_send && i_port_rst_n;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import bridge_ctl_pkg::*;
  logic i_clk = 1'h0, i_rst = 1'h1, up = 1'h0, wr = 1'h0, rd = 1'h0;
  logic io = 1'h0, win = 1'h0, poi = 1'h0, send = 1'h0, err;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'hF;
  logic [31:0] wdata = 32'h0, raddr = 32'h0, rdata;
  logic [NUM_DOWN_PORTS-1:0] upr = '0;
  logic rvalid, isa, disp, prep, efwd, hot, prst_n;
  int fails = 0, samples_checked = 0;
  bridge_control_pm_capability bridge_control_pm_capability_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_is_upstream(up), .i_cfg_wr(wr),
    .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata),
    .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .i_req_addr(raddr),
    .i_req_is_io(io), .i_req_in_io_window(win), .o_isa_upstream(isa),
    .o_disp_forward(disp), .i_sec_poisoned(poi), .i_sec_err_msg(err),
    .o_poison_report(prep), .o_err_msg_forward(efwd),
    .i_up_sec_reset(upr), .o_hot_reset(hot), .o_port_rst_n(prst_n));
  down_device_model down_device_model_inst (.i_clk(i_clk),
    .i_port_rst_n(prst_n), .i_send(send), .o_err_msg(err));
  initial forever #25 i_clk = ~i_clk;
  ////////////////////
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic cw(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk);
    wr <= 1'h1; addr <= a; wdata <= d;
    @(posedge i_clk);
    wr <= 1'h0;
  endtask
  task automatic cr(logic [7:0] a, logic [31:0] e);
    @(posedge i_clk);
    rd <= 1'h1; addr <= a;
    @(posedge i_clk);
    rd <= 1'h0;
    #1 chk("rdata", e, rdata);
    chk("rvalid", 32'h1, {31'h0, rvalid});
  endtask
  task automatic cls(logic [31:0] a, logic i, logic w, logic [1:0] e);
    @(posedge i_clk);
    raddr <= a; io <= i; win <= w;
    tick(2);
    chk("isa,disp", {30'h0, e}, {30'h0, isa, disp});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////
  initial begin
    #50000 fails++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'h0;
    cr(8'h3C, 32'h0);
    be <= 4'h8;
    cw(8'h3C, 32'hFFFF_FFFF);
    be <= 4'hF;
    cr(8'h3C, 32'h0);
    cw(8'h40, 32'h0);
    cr(8'h40, 32'hC803_4801);
    cr(8'h80, 32'h0);
    cw(8'h3C, 32'hFFFF_FFFF);
    cr(8'h3C, 32'h005F_0000);
    chk("hot,rst_n", 32'h2, {30'h0, hot, prst_n});
    $display("test registers done");
    cw(8'h3C, 32'h0003_0000);
    @(posedge i_clk);
    poi <= 1'h1; send <= 1'h1;
    tick(3);
    chk("poison,err", 32'h3, {30'h0, prep, efwd});
    cw(8'h3C, 32'h0);
    tick(2);
    chk("poison,err", 32'h0, {30'h0, prep, efwd});
    $display("test events done");
    cw(8'h3C, 32'h0008_0000);
    cls(32'h000A_0000, 1'h0, 1'h0, 2'h1);
    cls(32'h000C_0000, 1'h0, 1'h0, 2'h0);
    cls(32'h0000_13C5, 1'h1, 1'h0, 2'h1);
    cls(32'h0000_03BC, 1'h1, 1'h0, 2'h0);
    cw(8'h3C, 32'h0018_0000);
    cls(32'h0000_13C5, 1'h1, 1'h0, 2'h0);
    cls(32'h0000_03DF, 1'h1, 1'h0, 2'h1);
    cw(8'h3C, 32'h0004_0000);
    cls(32'h0000_0500, 1'h1, 1'h1, 2'h2);
    cls(32'h0000_04FF, 1'h1, 1'h1, 2'h0);
    cls(32'h0000_0500, 1'h1, 1'h0, 2'h0);
    cls(32'h0001_0500, 1'h1, 1'h1, 2'h0);
    $display("test decode done");
    @(posedge i_clk);
    upr[2] <= 1'h1;
    tick(2);
    chk("rst_n", 32'h0, {31'h0, prst_n});
    up <= 1'h1; upr <= '0;
    cw(8'h3C, 32'h0040_0000);
    tick(1);
    chk("hot,rst_n", 32'h3, {30'h0, hot, prst_n});
    $display("test resets done");
    test_done();
  end
endmodule
bind bridge_control_pm_capability bridge_control_pm_capability_sva
  bridge_control_pm_capability_sva_inst (.*);
`default_nettype wire
